// ===== verilog/vic_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Sample flags and decode priority every clock
// - Fastest response: one recognise, four call clocks
// - After return, one instruction before next call
// - Worst response eighteen clocks incl return, divide
// - Equal or higher in service blocks new request
// - Reset vector zero; vectors eight apart, index order
// - Hardware clears flags 0-3 and CAN on vectoring
// - LIN flag cleared only by its clear bit
// - Bit 7 gates all sources globally
// - Bits 6..0 enable the seven main sources
// - One enable covers all flags of a source
// - Enable register at 0xA8, bit access, resets zero
// - Extended enables and priorities for sources 7-22
// - Two levels; low preemptible, high never preempted
// - Higher level first, then fixed index order
// - Flag still set after return requests again
// - Software flag set acts like hardware request
module vic_top
    import vic_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    input  vic_sfr_s                 sfr,
    output logic [7:0]               sfr_rdata_ff,
    input  wire logic [6:0]          main_priority_reg,
    input  wire logic [7:0]          extended_enable_first,
    input  wire logic [7:0]          extended_enable_second,
    input  wire logic [7:0]          extended_priority_first,
    input  wire logic [7:0]          extended_priority_second,
    input  wire logic [NUM_SRC-1:0]  pend_set,
    input  wire logic [NUM_SRC-1:0]  pend_clr,
    input  wire logic                lin_flag_clear_bit,
    input  wire logic                cpu_call_start,
    input  wire logic                cpu_instr_done,
    input  wire logic                cpu_return_from_irq_op_done,
    output logic [NUM_SRC-1:0]       pend_flags_ff,
    output logic [7:0]               ie_ff,
    output logic                     irq_req_ff,
    output logic                     irq_high_ff,
    output logic [15:0]              irq_vector_ff,
    output logic [1:0]               in_service_ff
);

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    vic_state_e         state_ff;
    logic [2:0]         call_cnt_ff;
    logic [IDX_W-1:0]   idx_ff;
    logic [NUM_SRC-1:0] enables;
    logic [NUM_SRC-1:0] levels;
    logic [NUM_SRC-1:0] active;
    logic [NUM_SRC-1:0] hw_clr;
    vic_pick_s          pick;
    logic               cand_ok;
    logic [IDX_W-1:0]   cand_idx;
    logic               take;
    logic               ie_hit;
    logic               ie_bit_hit;

    //------------------------------------------------------------
    // Enable register access
    //------------------------------------------------------------
    assign ie_hit     = sfr.addr == IE_ADDR;
    assign ie_bit_hit = sfr.bit_addr[7:3] == IE_ADDR[7:3];

    // Byte and bit writes to the enable register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ie_ff <= IE_RESET;
        end else if (sfr.wr && ie_hit) begin
            ie_ff <= sfr.wdata;
        end else if (sfr.bit_wr && ie_bit_hit) begin
            ie_ff[sfr.bit_addr[2:0]] <= sfr.bit_val;
        end
    end

    // Read data, zero for other addresses
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sfr_rdata_ff <= 8'h00;
        end else if (sfr.rd && ie_hit) begin
            sfr_rdata_ff <= ie_ff;
        end else begin
            sfr_rdata_ff <= 8'h00;
        end
    end

    //------------------------------------------------------------
    // Masking and level maps
    //------------------------------------------------------------
    assign enables = {extended_enable_second, extended_enable_first,
                      ie_ff[IE_SRC_BITS-1:0]};
    assign levels  = {extended_priority_second, extended_priority_first,
                      main_priority_reg};
    // One enable per source, any flag of it raises pend_set
    assign active  = pend_flags_ff & enables
                   & {NUM_SRC{ie_ff[IE_GATE_BIT]}};

    vic_pick u_pick (
        .req    (active),
        .hi_sel (levels),
        .pick   (pick)
    );

    // Candidate must outrank whatever is in service
    always_comb begin
        cand_ok  = 1'b0;
        cand_idx = pick.lo_idx;
        if (pick.hi && !in_service_ff[1]) begin
            cand_ok  = 1'b1;
            cand_idx = pick.hi_idx;
        end else if (pick.lo && in_service_ff == 2'b00) begin
            cand_ok  = 1'b1;
        end
    end

    assign take = state_ff == ST_REQ && cpu_call_start;

    //------------------------------------------------------------
    // Pending flags, set wins over every clear
    //------------------------------------------------------------
    always_comb begin
        hw_clr = '0;
        if (take) begin
            hw_clr[idx_ff] = HW_CLEAR_MASK[idx_ff];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_flag
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    pend_flags_ff[g] <= 1'b0;
                end else if (LIVE_MASK[g]) begin
                    pend_flags_ff[g] <= pend_set[g];
                end else if (pend_set[g]) begin
                    pend_flags_ff[g] <= 1'b1;
                end else if ((pend_clr[g] && g != LIN_SRC) || hw_clr[g]) begin
                    pend_flags_ff[g] <= 1'b0;
                end else if (g == LIN_SRC && lin_flag_clear_bit) begin
                    pend_flags_ff[g] <= 1'b0;
                end
            end
        end
    endgenerate

    //------------------------------------------------------------
    // Request sequencer
    //------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
        end else if (cpu_return_from_irq_op_done) begin
            state_ff <= ST_AFTER_RETURN_FROM_IRQ_OP;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (cand_ok) begin
                        state_ff <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (cpu_call_start) begin
                        state_ff <= ST_CALL;
                    end else if (!cand_ok) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_CALL: begin
                    if (call_cnt_ff == CALL_LAST) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_AFTER_RETURN_FROM_IRQ_OP: begin
                    if (cpu_instr_done) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Long call clock count
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state_ff != ST_CALL) begin
            call_cnt_ff <= 3'h0;
        end else begin
            call_cnt_ff <= call_cnt_ff + 3'h1;
        end
    end

    // Request output, vector and level, re-decoded each idle or request clock without a take or return
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_req_ff    <= 1'b0;
            irq_high_ff   <= 1'b0;
            idx_ff        <= '0;
            irq_vector_ff <= RESET_VECTOR;
        end else if ((state_ff == ST_IDLE || state_ff == ST_REQ)
                     && !take && !cpu_return_from_irq_op_done && cand_ok) begin
            irq_req_ff    <= 1'b1;
            irq_high_ff   <= pick.hi && !in_service_ff[1];
            idx_ff        <= cand_idx;
            irq_vector_ff <= VEC_BASE
                           + {8'h00, cand_idx, 3'b000};
        end else begin
            irq_req_ff    <= 1'b0;
        end
    end

    // In-service levels, pushed on call and popped on return
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_service_ff <= 2'b00;
        end else if (take) begin
            if (irq_high_ff) begin
                in_service_ff[1] <= 1'b1;
            end else begin
                in_service_ff[0] <= 1'b1;
            end
        end else if (cpu_return_from_irq_op_done) begin
            if (in_service_ff[1]) begin
                in_service_ff[1] <= 1'b0;
            end else begin
                in_service_ff[0] <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_reset_vector: assert property (disable iff (1'b0)
        $past(sys_rst) |-> irq_vector_ff == RESET_VECTOR && !irq_req_ff)
        else $error("vector not zero after reset");
    a_vector_map: assert property (
        irq_req_ff |-> irq_vector_ff == VEC_BASE
                        + {8'h00, idx_ff, 3'b000})
        else $error("vector does not match source");
    a_gate_blocks: assert property (
        !ie_ff[IE_GATE_BIT] && state_ff != ST_REQ |=> !irq_req_ff)
        else $error("request with global gate off");
    a_recognise_one: assert property (
        state_ff == ST_IDLE && cand_ok && !cpu_return_from_irq_op_done |=> irq_req_ff)
        else $error("request not seen within one clock");
    a_call_length: assert property (
        take |=> (state_ff == ST_CALL && !irq_req_ff)[*4]
                 ##1 state_ff != ST_CALL)
        else $error("long call not four clocks");
    a_hw_clear: assert property (
        take && HW_CLEAR_MASK[idx_ff] && !pend_set[idx_ff]
        |=> !pend_flags_ff[$past(idx_ff)])
        else $error("flag not cleared on vectoring");
    a_lin_kept: assert property (
        take && idx_ff == 5'(LIN_SRC) && !lin_flag_clear_bit
        && pend_flags_ff[LIN_SRC] |=> pend_flags_ff[LIN_SRC])
        else $error("lin flag cleared by vectoring");
    a_return_from_irq_op_hold: assert property (
        cpu_return_from_irq_op_done ##1 !cpu_instr_done |=> !irq_req_ff)
        else $error("request before instruction after return");
    a_high_no_preempt: assert property (
        in_service_ff[1] |-> !irq_req_ff)
        else $error("high level routine preempted");
    a_sw_set: assert property (
        |pend_set |=> (pend_flags_ff & $past(pend_set))
                      == $past(pend_set))
        else $error("set flag lost");

endmodule

// ===== verilog/vic_pkg.sv
package vic_pkg;

    //------------------------------------------------------------
    // Source count and special-register map
    //------------------------------------------------------------
    localparam int        NUM_SRC        = 23;
    localparam int        IDX_W          = 5;
    localparam logic [7:0] IE_ADDR       = 8'hA8;
    localparam logic [7:0] IE_RESET      = 8'h00;
    localparam int        IE_GATE_BIT    = 7;
    localparam int        IE_SRC_BITS    = 7;
    localparam int        EXT_BITS       = 8;
    localparam int        EXT1_FIRST_SRC = 7;
    localparam int        EXT2_FIRST_SRC = 15;

    //------------------------------------------------------------
    // Vector layout
    //------------------------------------------------------------
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VEC_BASE     = 16'h0003;
    localparam int          VEC_SHIFT    = 3;

    //------------------------------------------------------------
    // Source indices with special flag handling
    //------------------------------------------------------------
    localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 23'h01000F;
    localparam logic [NUM_SRC-1:0] LIVE_MASK     = 23'h028000;
    localparam int                 LIN_SRC       = 14;

    //------------------------------------------------------------
    // Timing in system clocks
    //------------------------------------------------------------
    localparam int          RECOG_CYCLES = 1;
    localparam int          LONG_CALL_OP_CYCLES = 4;
    localparam int          RETURN_FROM_IRQ_OP_CYCLES  = 5;
    localparam int          DIV_CYCLES   = 8;
    localparam int          MIN_RESPONSE = RECOG_CYCLES + LONG_CALL_OP_CYCLES;
    localparam int          MAX_RESPONSE = RECOG_CYCLES + RETURN_FROM_IRQ_OP_CYCLES
                                         + DIV_CYCLES + LONG_CALL_OP_CYCLES;
    localparam logic [2:0]  CALL_LAST    = 3'(LONG_CALL_OP_CYCLES - 1);

    //------------------------------------------------------------
    // Types
    //------------------------------------------------------------
    typedef struct packed {
        logic             hi;
        logic             lo;
        logic [IDX_W-1:0] hi_idx;
        logic [IDX_W-1:0] lo_idx;
    } vic_pick_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       bit_wr;
        logic [7:0] bit_addr;
        logic       bit_val;
    } vic_sfr_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_CALL,
        ST_AFTER_RETURN_FROM_IRQ_OP
    } vic_state_e;

endpackage

// ===== verilog/vic_pick.sv
`timescale 1ns/1ns
module vic_pick
    import vic_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] req,
    input  wire logic [NUM_SRC-1:0] hi_sel,
    output vic_pick_s               pick
);

    //------------------------------------------------------------
    // Split requests by level
    //------------------------------------------------------------
    logic [NUM_SRC-1:0] hi_req;
    logic [NUM_SRC-1:0] lo_req;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_split
            assign hi_req[g] = req[g] & hi_sel[g];
            assign lo_req[g] = req[g] & ~hi_sel[g];
        end
    endgenerate

    // Lowest index wins within a level
    always_comb begin
        pick = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (hi_req[i]) begin
                pick.hi     = 1'b1;
                pick.hi_idx = IDX_W'(i);
            end
            if (lo_req[i]) begin
                pick.lo     = 1'b1;
                pick.lo_idx = IDX_W'(i);
            end
        end
    end

endmodule

// ===== verification/vic_cpu_model.sv
`timescale 1ns/1ns
// --------
// Core model: takes requests, runs call, return, one instruction
// --------
module vic_cpu_model
    import vic_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       irq_req_ff,
    input  wire logic       take_en,
    input  wire logic       return_from_irq_op_go,
    input  wire logic [3:0] instr_len,
    output logic            cpu_call_start,
    output logic            cpu_instr_done,
    output logic            cpu_return_from_irq_op_done
);
    logic [1:0] mode;
    logic [3:0] cnt;

    // Sequencer; take_en low stalls the call
    always @(posedge sys_clk) begin
        cpu_call_start <= 1'b0;
        cpu_return_from_irq_op_done  <= 1'b0;
        cpu_instr_done <= 1'b0;
        cnt            <= cnt - 4'h1;
        if (sys_rst) begin
            mode <= 2'h0;
            cnt  <= 4'h0;
        end else if (mode == 2'h0) begin
            if (irq_req_ff && take_en) begin
                cpu_call_start <= 1'b1;
                mode           <= 2'h1;
                cnt            <= 4'(LONG_CALL_OP_CYCLES - 1);
            end else if (return_from_irq_op_go) begin
                mode <= 2'h2;
                cnt  <= 4'(RETURN_FROM_IRQ_OP_CYCLES - 1);
            end
        end else if (cnt == 4'h0) begin
            if (mode == 2'h2) begin
                cpu_return_from_irq_op_done <= 1'b1;
                mode          <= 2'h3;
                cnt           <= instr_len - 4'h1;
            end else begin
                cpu_instr_done <= (mode == 2'h3);
                mode           <= 2'h0;
            end
        end
    end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ns
module testbench
    import vic_pkg::*;
;
    vic_sfr_s           sfr;
    logic [6:0]         mp;
    logic [7:0]         ee1, ee2, ep1, ep2, rdata, en_reg;
    logic [NUM_SRC-1:0] pset, pclr, flags;
    logic [15:0]        vec;
    logic [1:0]         insv;
    logic [3:0]         ilen;
    logic               sys_clk, sys_rst, lclr, take_en, return_from_irq_op_go;
    logic               req, hi, call, idone, rdone;
    int                 num_errors, checked, n;

    // --------
    // Design and core model
    // --------
    vic_top i_vic_top(.sys_clk, .sys_rst, .sfr, .sfr_rdata_ff(rdata),
        .main_priority_reg(mp), .extended_enable_first(ee1),
        .extended_enable_second(ee2), .extended_priority_first(ep1),
        .extended_priority_second(ep2), .pend_set(pset), .pend_clr(pclr),
        .lin_flag_clear_bit(lclr), .cpu_call_start(call),
        .cpu_instr_done(idone), .cpu_return_from_irq_op_done(rdone),
        .pend_flags_ff(flags), .ie_ff(en_reg), .irq_req_ff(req),
        .irq_high_ff(hi), .irq_vector_ff(vec), .in_service_ff(insv));
    vic_cpu_model i_vic_cpu_model(.sys_clk, .sys_rst, .irq_req_ff(req),
        .take_en, .return_from_irq_op_go, .instr_len(ilen), .cpu_call_start(call),
        .cpu_instr_done(idone), .cpu_return_from_irq_op_done(rdone));

    // --------
    // Tasks
    // --------
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    task automatic chk(input string nm, input logic [23:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // One register access: byte write, read or bit write
    task automatic bus(input logic w, r, bw, input logic [7:0] a, d);
        @(posedge sys_clk);
        sfr <= {w, r, a, d, bw, a, d[0]};
        @(posedge sys_clk);
        sfr <= '0;
    endtask

    task automatic rd(input logic [7:0] a, e);
        bus(1'b0, 1'b1, 1'b0, a, 8'h00);
        #1 chk("read data", e, rdata);
    endtask

    // One-clock pulses on flag set, clear and the link clear bit
    task automatic pulse(input logic [22:0] s, c, input logic l);
        @(posedge sys_clk);
        pset <= s;
        pclr <= c;
        lclr <= l;
        @(posedge sys_clk);
        pset <= '0;
        pclr <= '0;
        lclr <= 1'b0;
    endtask

    // Wait for the core to take a request
    task automatic waitc;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (call !== 1'b1 && n < 50);
        #1 chk("call taken", 1, n < 50);
    endtask

    // Return plus one instruction; no request meanwhile
    // Return request held until the core reports it done
    task automatic wret(input logic [3:0] len);
        @(posedge sys_clk);
        ilen    <= len;
        return_from_irq_op_go <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (rdone === 1'b1) begin
                return_from_irq_op_go <= 1'b0;
            end
            chk("request held", 0, req);
        end while (idone !== 1'b1 && n < 40);
        chk("instr done", 1, n < 40);
    endtask

    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // --------
    // Clock, watchdog, tests
    // --------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        tick(20000);
        num_errors++;
        summarize();
    end

    initial begin
        {sfr, mp, ep1, ep2, pset, pclr, lclr, take_en, return_from_irq_op_go} = '0;
        {ee1, ee2} = 16'hFFFF;
        ilen = 4'h1;
        sys_rst = 1'b1;
        tick(5);
        sys_rst <= 1'b0;
        tick(1);
        #1 chk("enable reg", 8'h00, en_reg);
        chk("vector", 16'h0000, vec);
        rd(8'hA8, 8'h00);
        bus(1'b1, 1'b0, 1'b0, 8'hA8, 8'hFF);
        // Every source alone: timing, vector, clearing
        for (int i = 0; i < NUM_SRC; i++) begin
            pulse(23'h1 << i, 23'h0, 1'b0);
            #1 chk("early request", 0, req);
            tick(1);
            #1 chk("request", 1, req);
            chk("vector", 16'h0003 + 16'(8 * i), vec);
            if (i == 14) begin
                pulse(23'h0, 23'h1 << i, 1'b0);
                #1 chk("link flag", 1, flags[14]);
                pulse(23'h0, 23'h0, 1'b1);
            end else begin
                pulse(23'h0, 23'h1 << i, 1'b0);
            end
            tick(1);
            #1 chk("flags", 23'h0, flags);
        end
        // Tie-break and level order
        pulse(23'h7FFFFF, 23'h0, 1'b0);
        tick(1);
        #1 chk("vector", 16'h0003, vec);
        ep2 <= 8'h20;
        tick(2);
        #1 chk("vector", 16'h00A3, vec);
        chk("high level", 1, hi);
        mp <= 7'h40;
        tick(2);
        #1 chk("vector", 16'h0033, vec);
        pulse(23'h0, 23'h7FFFFF, 1'b1);
        mp <= 7'h00;
        ep2 <= 8'h00;
        // Global gate and per-source bits
        bus(1'b1, 1'b0, 1'b0, 8'hA8, 8'h7F);
        pulse(23'h1, 23'h0, 1'b0);
        tick(1);
        #1 chk("gated request", 0, req);
        bus(1'b0, 1'b0, 1'b1, 8'hAF, 8'h01);
        #1 chk("enable reg", 8'hFF, en_reg);
        tick(1);
        #1 chk("request", 1, req);
        bus(1'b0, 1'b0, 1'b1, 8'hA8, 8'h00);
        #1 chk("enable reg", 8'hFE, en_reg);
        tick(1);
        #1 chk("masked request", 0, req);
        bus(1'b1, 1'b0, 1'b0, 8'hA8, 8'h90);
        pulse(23'h7F, 23'h0, 1'b0);
        tick(1);
        #1 chk("vector", 16'h0023, vec);
        bus(1'b1, 1'b0, 1'b0, 8'hA9, 8'h55);
        rd(8'hA8, 8'h90);
        rd(8'hA9, 8'h00);
        // Service, nesting, returns
        pulse(23'h0, 23'h2F, 1'b0);
        bus(1'b1, 1'b0, 1'b0, 8'hA8, 8'hFF);
        take_en <= 1'b1;
        waitc();
        chk("in service", 2'b01, insv);
        chk("sw flag kept", 1, flags[4]);
        tick(6);
        #1 chk("equal request", 0, req);
        mp <= 7'h21;
        pulse(23'h20, 23'h0, 1'b0);
        tick(1);
        #1 chk("preempt vector", 16'h002B, vec);
        waitc();
        chk("in service", 2'b11, insv);
        pulse(23'h1, 23'h20, 1'b0);
        tick(6);
        #1 chk("high preempt", 0, req);
        wret(4'(DIV_CYCLES));
        tick(2);
        #1 chk("request", 1, req);
        chk("vector", 16'h0003, vec);
        chk("in service", 2'b01, insv);
        waitc();
        chk("hw cleared", 0, flags[0]);
        wret(4'h1);
        tick(3);
        #1 chk("equal request", 0, req);
        wret(4'h1);
        tick(2);
        #1 chk("vector", 16'h0023, vec);
        chk("request", 1, req);
        // Link source at high level preempts; vectoring keeps its flag
        ep1 <= 8'h80;
        pulse(23'h4000, 23'h0, 1'b0);
        waitc();
        chk("vector", 16'h0073, vec);
        chk("in service", 2'b11, insv);
        chk("link flag", 1, flags[14]);
        summarize();
    end
endmodule
